// ===== mem_power_track.sv
// Tracks power-up of each RAM block and reports when it is fully on.
// Assumes keepOn comes from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mem_power_track
	import power_reset_pkg::*;
#(
	parameter int BLOCKS = MEM_BLOCKS
)(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [BLOCKS-1:0] keepOn,
	input wire logic sysOff,
	output logic [BLOCKS-1:0] poweredOn
);

	logic [3:0] cnt_ff [BLOCKS];
	logic [3:0] nxt_cnt [BLOCKS];
	logic [BLOCKS-1:0] nxt_poweredOn;

	// A block counts up while asked on and drops at once when switched off.
	always_comb
	begin
		for (int i = 0; i < BLOCKS; i++)
		begin
			nxt_cnt[i] = cnt_ff[i];
			if (!keepOn[i] || sysOff)
				nxt_cnt[i] = 4'h0;
			else if (cnt_ff[i] != MEM_UP_CYCLES)
				nxt_cnt[i] = cnt_ff[i] + 4'h1;
			nxt_poweredOn[i] = (nxt_cnt[i] == MEM_UP_CYCLES);
		end
	end

	// Registers only.
	always_ff @(posedge mclk)
	begin
		for (int i = 0; i < BLOCKS; i++)
		begin
			if (rst)
				cnt_ff[i] <= 4'h0;
			else
				cnt_ff[i] <= nxt_cnt[i];
		end
		if (rst)
			poweredOn <= '0;
		else
			poweredOn <= nxt_poweredOn;
	end

endmodule // mem_power_track
`default_nettype wire

// ===== power_reset_control.sv
// Power and reset control: reset routing, reset-cause record, sleep
// sub-mode, supply-fail warning, System OFF entry and retained registers.
// Assumes AHB-Lite single word transfers and a 20 MHz mclk; the power-on
// and brown-out reset both arrive as the synchronous rst input.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
module power_reset_control
	import power_reset_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic pinResetN,
	input wire logic dogExpire,
	input wire logic softReq,
	input wire logic lockup,
	input wire logic gpioDetect,
	input wire logic compDetect,
	input wire logic debugEnter,
	input wire logic debugMode,
	input wire logic supplyLow,
	output rst_targets_s rstOut,
	output logic sysOff,
	output logic constLatency,
	output logic pfIrq,
	output mem_ctrl_s memCtrl,
	output logic pfEnable,
	output logic [1:0] pfThreshold,
	output logic regulatorOn
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] pinSync_ff;
	logic [1:0] gpioSync_ff;
	logic [1:0] compSync_ff;
	logic [1:0] lowSync_ff;
	logic [1:0] dbgSync_ff;
	logic [1:0] dbgEnSync_ff;
	logic pinRst;

	// Asynchronous pins pass two flops; only stage one is read by stage two.
	always_ff @(posedge mclk)
	begin
		pinSync_ff <= {pinSync_ff[0], ~pinResetN};
		gpioSync_ff <= {gpioSync_ff[0], gpioDetect};
		compSync_ff <= {compSync_ff[0], compDetect};
		lowSync_ff <= {lowSync_ff[0], supplyLow};
		dbgSync_ff <= {dbgSync_ff[0], debugMode};
		dbgEnSync_ff <= {dbgEnSync_ff[0], debugEnter};
	end
	assign pinRst = pinSync_ff[1];

	// ****************************************************************
	// Bus slave
	// ****************************************************************
	logic wrPend_ff;
	logic nxt_wrPend;
	logic [11:0] wrAddr_ff;
	logic [11:0] nxt_wrAddr;
	logic [31:0] nxt_hrdata;
	logic addrPhase;
	logic wrStrobe;

	assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
	assign wrStrobe = wrPend_ff;

	// Writes land in the data phase; reads are muxed in the address phase.
	always_comb
	begin
		nxt_wrPend = addrPhase && hwrite;
		nxt_wrAddr = addrPhase ? haddr[11:0] : wrAddr_ff;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wrPend_ff <= nxt_wrPend;
			wrAddr_ff <= nxt_wrAddr;
			hrdata <= nxt_hrdata;
			hreadyout <= 1'b1; // Zero wait states, always OKAY.
			hresp <= 1'b0;
		end
	end

	function automatic logic wrHit(input logic [11:0] ofs);
		wrHit = wrStrobe && wrAddr_ff == ofs;
	endfunction

	// ****************************************************************
	// Reset routing
	// ****************************************************************
	rst_kind_e kind;
	rst_kind_e kind_ff;
	logic pinInDebug_ff;
	rst_targets_s nxt_rstOut;
	logic offNow_ff;

	reset_kind_sel uKind (
		.pinRst(pinRst),
		.dogExpire(dogExpire),
		.softReq(softReq),
		.lockup(lockup),
		.wake(gpioSync_ff[1] || compSync_ff[1] || dbgEnSync_ff[1]),
		.debugMode(dbgSync_ff[1]),
		.pinInDebug(pinInDebug_ff),
		.sysOff(offNow_ff),
		.kind(kind)
	);

	// Target strobes per kind; RAM is never wiped, only its controls.
	always_comb
	begin
		nxt_rstOut = '0;
		unique case (kind)
			RS_NONE: nxt_rstOut = '0;
			RS_LOCK, RS_SOFT:
			begin
				nxt_rstOut.cpu = 1'b1;
				nxt_rstOut.periph = 1'b1;
				nxt_rstOut.gpio = 1'b1;
			end
			RS_WAKE:
			begin
				nxt_rstOut.cpu = 1'b1;
				nxt_rstOut.periph = 1'b1;
				nxt_rstOut.debug = 1'b1;
				nxt_rstOut.debugPort = !dbgSync_ff[1];
				nxt_rstOut.mem = 1'b1;
			end
			RS_DOG, RS_PIN:
			begin
				nxt_rstOut = '1;
			end
			default: nxt_rstOut = '0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rstOut <= '1;
			kind_ff <= RS_NONE;
		end
		else
		begin
			rstOut <= nxt_rstOut;
			kind_ff <= kind;
		end
	end

	// ****************************************************************
	// Control and retained registers
	// ****************************************************************
	logic nxt_sysOff;
	logic nxt_constLatency;
	logic irqEn_ff;
	logic nxt_irqEn;
	logic pfEvent_ff;
	logic nxt_pfEvent;
	logic nxt_pfEnable;
	logic [1:0] nxt_pfThreshold;
	logic [31:0] gpWord_ff;
	logic [31:0] nxt_gpWord;
	mem_ctrl_s nxt_memCtrl;
	logic nxt_pinInDebug;
	logic nxt_regulatorOn;
	logic [6:0] cause_ff;
	logic [6:0] nxt_cause;
	logic [6:0] causeSet;
	logic [6:0] causeClr;
	logic retClear;

	// Only watchdog and pin resets reach the retained registers.
	assign retClear = kind_ff == RS_DOG || kind_ff == RS_PIN;

	// Cause bits packed as pin, dog, soft, lockup, gpio, comp, debug.
	always_comb
	begin
		causeSet = 7'h00;
		unique case (kind_ff)
			RS_PIN: causeSet[0] = 1'b1;
			RS_DOG: causeSet[1] = 1'b1;
			RS_SOFT: causeSet[2] = 1'b1;
			RS_LOCK: causeSet[3] = 1'b1;
			RS_WAKE: causeSet[6:4] = {dbgEnSync_ff[1], compSync_ff[1],
				gpioSync_ff[1]};
			RS_NONE: causeSet = 7'h00;
			default: causeSet = 7'h00;
		endcase
		causeClr = 7'h00;
		if (wrHit(OFS_RST_CAUSE))
			causeClr = {hwdata[CAUSE_DBG], hwdata[CAUSE_COMP],
				hwdata[CAUSE_GPIO], hwdata[CAUSE_LOCK],
				hwdata[CAUSE_SOFT], hwdata[CAUSE_DOG], hwdata[CAUSE_PIN]};
		// A new cause in the clearing cycle survives the clear.
		nxt_cause = (cause_ff & ~causeClr) | causeSet;
	end

	// Software controlled state and the warning event.
	always_comb
	begin
		nxt_sysOff = sysOff;
		if (wrHit(OFS_OFF_ENTRY) && hwdata[0])
			nxt_sysOff = 1'b1;
		if (kind_ff == RS_WAKE)
			nxt_sysOff = 1'b0;
		nxt_constLatency = constLatency;
		if (wrHit(OFS_CONST_LAT))
			nxt_constLatency = 1'b1;
		if (wrHit(OFS_LOW_PWR))
			nxt_constLatency = 1'b0;
		if (kind_ff != RS_NONE)
			nxt_constLatency = 1'b0;
		nxt_irqEn = irqEn_ff;
		if (wrHit(OFS_IRQ_SET) && hwdata[IRQ_PF_BIT])
			nxt_irqEn = 1'b1;
		if (wrHit(OFS_IRQ_CLR) && hwdata[IRQ_PF_BIT])
			nxt_irqEn = 1'b0;
		nxt_pfEvent = pfEvent_ff;
		if (wrHit(OFS_PF_WARN))
			nxt_pfEvent = hwdata[0];
		if (pfEnable && lowSync_ff[1])
			nxt_pfEvent = 1'b1;
		nxt_pfEnable = pfEnable;
		nxt_pfThreshold = pfThreshold;
		if (wrHit(OFS_PF_CFG))
		begin
			nxt_pfEnable = hwdata[0];
			nxt_pfThreshold = hwdata[PF_THR_LSB +: 2];
		end
		nxt_gpWord = gpWord_ff;
		if (wrHit(OFS_GP_RET))
			nxt_gpWord = hwdata;
		nxt_memCtrl = memCtrl;
		if (wrHit(OFS_MEM_LOW))
		begin
			nxt_memCtrl.keepOn[1:0] = hwdata[1:0];
			nxt_memCtrl.keepRet[1:0] = hwdata[17:16];
		end
		if (wrHit(OFS_MEM_HIGH))
		begin
			nxt_memCtrl.keepOn[3:2] = hwdata[1:0];
			nxt_memCtrl.keepRet[3:2] = hwdata[17:16];
		end
		nxt_pinInDebug = pinInDebug_ff;
		if (wrHit(OFS_RST_CFG))
			nxt_pinInDebug = hwdata[0];
		nxt_regulatorOn = regulatorOn;
		if (wrHit(OFS_REG_EN))
			nxt_regulatorOn = hwdata[0];
		if (retClear)
		begin
			nxt_gpWord = 32'h00000000;
			nxt_memCtrl = {MEM_RST, 4'h0};
			nxt_pinInDebug = 1'b0;
		end
	end

	// Registers only; rst is power-on or brown-out and clears everything except keepOn, which loads MEM_RST.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			sysOff <= 1'b0;
			offNow_ff <= 1'b0;
			constLatency <= 1'b0;
			irqEn_ff <= 1'b0;
			pfEvent_ff <= 1'b0;
			pfIrq <= 1'b0;
			pfEnable <= 1'b0;
			pfThreshold <= 2'h0;
			gpWord_ff <= 32'h00000000;
			memCtrl <= {MEM_RST, 4'h0};
			pinInDebug_ff <= 1'b0;
			regulatorOn <= 1'b0;
			cause_ff <= 7'h00;
		end
		else
		begin
			sysOff <= nxt_sysOff;
			offNow_ff <= nxt_sysOff;
			constLatency <= nxt_constLatency;
			irqEn_ff <= nxt_irqEn;
			pfEvent_ff <= nxt_pfEvent;
			pfIrq <= nxt_pfEvent && nxt_irqEn;
			pfEnable <= nxt_pfEnable;
			pfThreshold <= nxt_pfThreshold;
			gpWord_ff <= nxt_gpWord;
			memCtrl <= nxt_memCtrl;
			pinInDebug_ff <= nxt_pinInDebug;
			regulatorOn <= nxt_regulatorOn;
			cause_ff <= nxt_cause;
		end
	end

	// ****************************************************************
	// RAM status and read mux
	// ****************************************************************
	logic [3:0] memUp;

	mem_power_track #(
		.BLOCKS(MEM_BLOCKS)
	) uMem (
		.mclk(mclk),
		.rst(rst),
		.keepOn(memCtrl.keepOn),
		.sysOff(sysOff),
		.poweredOn(memUp)
	);

	// Unmapped and write-only addresses read as zero.
	always_comb
	begin
		nxt_hrdata = hrdata;
		if (addrPhase && !hwrite)
		begin
			nxt_hrdata = 32'h00000000;
			unique case (haddr[11:0])
				OFS_PF_WARN: nxt_hrdata[0] = pfEvent_ff;
				OFS_IRQ_SET, OFS_IRQ_CLR:
					nxt_hrdata[IRQ_PF_BIT] = irqEn_ff;
				OFS_RST_CAUSE:
				begin
					nxt_hrdata[3:0] = cause_ff[3:0];
					nxt_hrdata[CAUSE_DBG:CAUSE_GPIO] = cause_ff[6:4];
				end
				OFS_MEM_STAT: nxt_hrdata[3:0] = memUp;
				OFS_PF_CFG: nxt_hrdata[2:0] = {pfThreshold, pfEnable};
				OFS_GP_RET: nxt_hrdata = gpWord_ff;
				OFS_MEM_LOW: nxt_hrdata = {14'h0000,
					memCtrl.keepRet[1:0], 14'h0000, memCtrl.keepOn[1:0]};
				OFS_MEM_HIGH: nxt_hrdata = {14'h0000,
					memCtrl.keepRet[3:2], 14'h0000, memCtrl.keepOn[3:2]};
				OFS_RST_CFG: nxt_hrdata[0] = pinInDebug_ff;
				OFS_REG_EN: nxt_hrdata[0] = regulatorOn;
				OFS_SUBMODE: nxt_hrdata[0] = constLatency;
				default: nxt_hrdata = 32'h00000000;
			endcase
		end
	end

endmodule // power_reset_control
`default_nettype wire

// ===== power_reset_control_asserts.sv
// Concurrent checks on the ports of the power and reset control block.
// Assumes single-word AHB-Lite writes with zero wait states upstream.
`timescale 1ns/100ps
`default_nettype none
module power_reset_control_asserts
	import power_reset_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic pinResetN,
	input wire logic dogExpire,
	input wire logic softReq,
	input wire logic lockup,
	input wire logic debugMode,
	input wire rst_targets_s rstOut,
	input wire logic sysOff,
	input wire logic pfEnable,
	input wire logic [1:0] pfThreshold,
	input wire logic regulatorOn
);
	// ************************************************************
	// Helper state
	// ************************************************************
	logic [2:0] pinCnt_ff, nxt_pinCnt, dbgCnt_ff, nxt_dbgCnt;
	logic aWr_ff, nxt_aWr, dWr_ff, nxt_dWr;
	logic [11:0] aAdr_ff, nxt_aAdr, wAdr_ff, nxt_wAdr;
	logic [31:0] wDat_ff, nxt_wDat;
	logic pinIdle, dbgOn;

	// Count settled pin and debug levels, so the two-flop sync has passed.
	always_comb
	begin
		nxt_pinCnt = !pinResetN ? 3'h0 : pinCnt_ff + {2'h0, pinCnt_ff != 3'h7};
		nxt_dbgCnt = !debugMode ? 3'h0 : dbgCnt_ff + {2'h0, dbgCnt_ff != 3'h7};
		nxt_aWr = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
		nxt_aAdr = haddr[11:0];
		nxt_dWr = aWr_ff && hready;
		nxt_wAdr = aAdr_ff;
		nxt_wDat = hwdata;
	end

	// Registers of the helper logic; data is caught at the data phase end.
	always_ff @(posedge mclk)
	begin
		pinCnt_ff <= rst ? 3'h0 : nxt_pinCnt;
		dbgCnt_ff <= rst ? 3'h0 : nxt_dbgCnt;
		aWr_ff <= rst ? 1'b0 : nxt_aWr;
		aAdr_ff <= nxt_aAdr;
		dWr_ff <= rst ? 1'b0 : nxt_dWr;
		wAdr_ff <= nxt_wAdr;
		wDat_ff <= nxt_wDat;
	end

	assign pinIdle = pinCnt_ff >= 3'h4;
	assign dbgOn = dbgCnt_ff >= 3'h4;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	AST_DOG: assert property (!sysOff && dogExpire |=>
		rstOut.watchdog && rstOut.debug && rstOut.cpu)
		else $error("Watchdog expiry gave no watchdog reset.");
	AST_DOG_OFF: assert property (sysOff && pinIdle |=>
		!rstOut.watchdog)
		else $error("Watchdog reset seen in System OFF.");
	AST_LOCK_DBG: assert property (pinIdle && dbgOn && lockup
		&& !softReq && !dogExpire && !sysOff |=> rstOut == '0)
		else $error("Lockup reset taken in debug mode.");
	AST_SOFT: assert property (pinIdle && softReq && !dogExpire
		&& !sysOff |=> rstOut.cpu && rstOut.gpio
		&& !rstOut.watchdog && !rstOut.debug)
		else $error("Soft reset targets wrong.");
	AST_WAKE_DAP: assert property (rstOut.cpu && !rstOut.gpio
		&& dbgOn |-> !rstOut.debugPort && rstOut.debug)
		else $error("Wake reset touched the debug port.");
	AST_WAKE_OFF: assert property (rstOut.cpu && !rstOut.gpio
		|-> $past(sysOff) && rstOut.periph)
		else $error("Wake reset outside System OFF.");
	AST_ENTRY: assert property (dWr_ff && wAdr_ff == OFS_OFF_ENTRY
		&& wDat_ff[0] |-> ##[0:2] sysOff)
		else $error("System OFF not entered.");
	AST_PF_CFG: assert property (dWr_ff && wAdr_ff == OFS_PF_CFG |->
		##[0:2] pfEnable == wDat_ff[0] && pfThreshold == wDat_ff[2:1])
		else $error("Supply-fail config not applied.");
	AST_REG_EN: assert property (dWr_ff && wAdr_ff == OFS_REG_EN |->
		##[0:2] regulatorOn == wDat_ff[0])
		else $error("Regulator enable not applied.");

	CV_WAKE: cover property (rstOut.cpu && !rstOut.gpio && dbgOn);
	CV_DOG: cover property (!sysOff && dogExpire);
	CV_SOFT: cover property (pinIdle && softReq && !sysOff);
endmodule // power_reset_control_asserts

bind power_reset_control power_reset_control_asserts
	u_power_reset_control_asserts (
	.mclk(mclk),
	.rst(rst),
	.hsel(hsel),
	.haddr(haddr),
	.htrans(htrans),
	.hwrite(hwrite),
	.hwdata(hwdata),
	.hready(hready),
	.pinResetN(pinResetN),
	.dogExpire(dogExpire),
	.softReq(softReq),
	.lockup(lockup),
	.debugMode(debugMode),
	.rstOut(rstOut),
	.sysOff(sysOff),
	.pfEnable(pfEnable),
	.pfThreshold(pfThreshold),
	.regulatorOn(regulatorOn)
);
`default_nettype wire

// ===== power_reset_control_tb.sv
// Self-checking bench for the power and reset control block.
// Assumes the block answers AHB-Lite with hreadyout and no wait limit.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin fails++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (e)); \
	end end
module power_reset_control_tb
	import power_reset_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	localparam logic [31:0] GPV = 32'hA5C3_0F96;
	// Interrupt enable bit of the power-fail warning.
	localparam logic [31:0] IRQ_MASK = 32'h0000_0004;
	logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic pinResetN, dogExpire, softReq, lockup, gpioDetect;
	logic compDetect, debugEnter, debugMode, supplyLow;
	logic sysOff, constLatency, pfIrq, pfEnable, regulatorOn;
	logic [31:0] haddr, hwdata, hrdata, exp;
	logic [1:0] htrans, pfThreshold;
	logic [2:0] hsize;
	rst_targets_s rstOut;
	mem_ctrl_s memCtrl;
	int fails = 0;
	int nTests = 0;
	int srcBit [3] = '{CAUSE_SOFT, CAUSE_LOCK, CAUSE_DOG};

	// The single slave's ready is the bus ready.
	assign hready = hreadyout;
	power_reset_control u_power_reset_control (
		.mclk(mclk),
		.rst(rst),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hready),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.pinResetN(pinResetN),
		.dogExpire(dogExpire),
		.softReq(softReq),
		.lockup(lockup),
		.gpioDetect(gpioDetect),
		.compDetect(compDetect),
		.debugEnter(debugEnter),
		.debugMode(debugMode),
		.supplyLow(supplyLow),
		.rstOut(rstOut),
		.sysOff(sysOff),
		.constLatency(constLatency),
		.pfIrq(pfIrq),
		.memCtrl(memCtrl),
		.pfEnable(pfEnable),
		.pfThreshold(pfThreshold),
		.regulatorOn(regulatorOn)
	);

	// ************************************************************
	// Tasks
	// ************************************************************
	// One AHB-Lite single transfer; waits are bounded by the watchdog.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		`CHK(q, e)
	endtask

	// Drives one reset or wake source; the pin is active low.
	task setSrc(input int k, input logic v);
		case (k)
			0: softReq <= v;
			1: lockup <= v;
			2: dogExpire <= v;
			3: gpioDetect <= v;
			4: compDetect <= v;
			5: debugEnter <= v;
			default: pinResetN <= !v;
		endcase
	endtask

	// Holds a source for len cycles, then lets the reset settle.
	task hit(input int k, input int len);
		@(posedge mclk);
		setSrc(k, 1'b1);
		repeat (len) @(posedge mclk);
		setSrc(k, 1'b0);
		repeat (6) @(posedge mclk);
	endtask

	task finalReport;
		$display("Comparisons %0d, mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and tests
	// ************************************************************
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Tests need about 400 cycles; this cuts a hang short.
	initial
	begin
		repeat (30000) @(posedge mclk);
		fails++;
		finalReport();
	end

	initial
	begin
		{hsel, hwrite, softReq, lockup, dogExpire, gpioDetect} = '0;
		{compDetect, debugEnter, debugMode, supplyLow} = '0;
		{haddr, hwdata, htrans} = '0;
		hsize = 3'h2;
		pinResetN = 1'b1;
		rst = 1'b1;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		`CHK(memCtrl.keepOn, MEM_RST)
		`CHK(constLatency, 1'b0)
		rd(OFS_RST_CAUSE, 32'h0);
		rd(12'hFFC, 32'h0);
		rd(OFS_MEM_STAT, {28'h0, MEM_RST});
		$display("Reset values done");
		for (int t = 0; t < 4; t++)
		begin
			wr(OFS_PF_CFG, {29'h0, t[1:0], 1'b1});
			rd(OFS_PF_CFG, {29'h0, t[1:0], 1'b1});
			`CHK(pfThreshold, t[1:0])
		end
		wr(OFS_GP_RET, GPV);
		rd(OFS_GP_RET, GPV);
		wr(OFS_REG_EN, 32'h1);
		rd(OFS_REG_EN, 32'h1);
		wr(OFS_MEM_LOW, 32'h0003_0001);
		wr(OFS_MEM_HIGH, 32'h0001_0002);
		rd(OFS_MEM_HIGH, 32'h0001_0002);
		`CHK(memCtrl, 8'h97)
		repeat (2 * MEM_UP_CYCLES) @(posedge mclk);
		wr(OFS_MEM_STAT, 32'h0);
		rd(OFS_MEM_STAT, 32'h9);
		$display("Register access done");
		wr(OFS_CONST_LAT, 32'h1);
		rd(OFS_SUBMODE, 32'h1);
		wr(OFS_LOW_PWR, 32'h1);
		rd(OFS_SUBMODE, 32'h0);
		`CHK(constLatency, 1'b0)
		@(posedge mclk);
		supplyLow <= 1'b1;
		repeat (4) @(posedge mclk);
		rd(OFS_PF_WARN, 32'h1);
		wr(OFS_IRQ_SET, 32'h0);
		rd(OFS_IRQ_SET, 32'h0);
		`CHK(pfIrq, 1'b0)
		wr(OFS_IRQ_SET, IRQ_MASK);
		rd(OFS_IRQ_CLR, IRQ_MASK);
		`CHK(pfIrq, 1'b1)
		wr(OFS_IRQ_CLR, 32'h0);
		rd(OFS_IRQ_SET, IRQ_MASK);
		wr(OFS_IRQ_CLR, IRQ_MASK);
		rd(OFS_IRQ_SET, 32'h0);
		supplyLow <= 1'b0;
		repeat (4) @(posedge mclk);
		wr(OFS_PF_WARN, 32'h0);
		rd(OFS_PF_WARN, 32'h0);
		$display("Sub-mode and warning done");
		exp = 32'h0;
		for (int k = 0; k < 3; k++)
		begin
			hit(k, 1);
			exp = exp | (32'h1 << srcBit[k]);
			rd(OFS_RST_CAUSE, exp);
			rd(OFS_GP_RET, (k == 2) ? 32'h0 : GPV);
		end
		wr(OFS_RST_CAUSE, 32'h1 << CAUSE_SOFT);
		rd(OFS_RST_CAUSE, exp & ~(32'h1 << CAUSE_SOFT));
		wr(OFS_RST_CAUSE, 32'hFFFF_FFFF);
		debugMode <= 1'b1;
		// The debug level passes two sync flops before it gates lockup.
		repeat (3) @(posedge mclk);
		hit(1, 1);
		rd(OFS_RST_CAUSE, 32'h0);
		hit(6, 3);
		rd(OFS_RST_CAUSE, 32'h0);
		wr(OFS_RST_CFG, 32'h1);
		hit(6, 3);
		rd(OFS_RST_CAUSE, 32'h1 << CAUSE_PIN);
		wr(OFS_RST_CAUSE, 32'hFFFF_FFFF);
		$display("Reset causes done");
		wr(OFS_GP_RET, GPV);
		for (int w = 3; w < 6; w++)
		begin
			wr(OFS_OFF_ENTRY, 32'h1);
			repeat (2) @(posedge mclk);
			`CHK(sysOff, 1'b1)
			hit(2, 1);
			hit(1, 1);
			rd(OFS_RST_CAUSE, 32'h0);
			hit(w, 4);
			`CHK(sysOff, 1'b0)
			rd(OFS_RST_CAUSE, 32'h1 << (CAUSE_GPIO + w - 3));
			wr(OFS_RST_CAUSE, 32'hFFFF_FFFF);
			rd(OFS_GP_RET, GPV);
		end
		$display("System OFF done");
		finalReport();
	end
endmodule // power_reset_control_tb
`default_nettype wire

// ===== power_reset_pkg.sv
// Package for the power and reset control block: register map, field
// positions, reset values and shared structs.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package power_reset_pkg;

	// ****************************************************************
	// Register byte offsets
	// ****************************************************************
	localparam logic [11:0] OFS_CONST_LAT = 12'h078;
	localparam logic [11:0] OFS_LOW_PWR = 12'h07C;
	localparam logic [11:0] OFS_PF_WARN = 12'h108;
	localparam logic [11:0] OFS_IRQ_SET = 12'h304;
	localparam logic [11:0] OFS_IRQ_CLR = 12'h308;
	localparam logic [11:0] OFS_RST_CAUSE = 12'h400;
	localparam logic [11:0] OFS_MEM_STAT = 12'h428;
	localparam logic [11:0] OFS_OFF_ENTRY = 12'h500;
	localparam logic [11:0] OFS_PF_CFG = 12'h510;
	localparam logic [11:0] OFS_GP_RET = 12'h51C;
	localparam logic [11:0] OFS_MEM_LOW = 12'h524;
	localparam logic [11:0] OFS_RST_CFG = 12'h544;
	localparam logic [11:0] OFS_MEM_HIGH = 12'h554;
	localparam logic [11:0] OFS_REG_EN = 12'h578;
	// Status of the sleep sub-mode, not printed in the map.
	localparam logic [11:0] OFS_SUBMODE = 12'h600;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int CAUSE_PIN = 0;
	localparam int CAUSE_DOG = 1;
	localparam int CAUSE_SOFT = 2;
	localparam int CAUSE_LOCK = 3;
	localparam int CAUSE_GPIO = 16;
	localparam int CAUSE_COMP = 17;
	localparam int CAUSE_DBG = 18;
	localparam int PF_THR_LSB = 1;
	// Enable bit of the warning interrupt in the set and clear registers.
	localparam int IRQ_PF_BIT = 2;
	// Both RAM control registers come out of reset with their blocks on.
	localparam logic [3:0] MEM_RST = 4'hF;
	localparam int MEM_BLOCKS = 4;
	// Cycles a RAM block takes to report powered after switch-on.
	localparam logic [3:0] MEM_UP_CYCLES = 4'h8;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		RS_NONE = 3'h0,
		RS_LOCK = 3'h1,
		RS_SOFT = 3'h2,
		RS_WAKE = 3'h3,
		RS_DOG = 3'h4,
		RS_PIN = 3'h5
	} rst_kind_e;

	// Per-target reset strobes handed to the rest of the chip.
	typedef struct packed {
		logic cpu;
		logic periph;
		logic gpio;
		logic debug;
		logic debugPort;
		logic mem;
		logic watchdog;
	} rst_targets_s;

	// RAM power controls for all blocks.
	typedef struct packed {
		logic [3:0] keepOn;
		logic [3:0] keepRet;
	} mem_ctrl_s;

endpackage

// ===== reset_kind_sel.sv
// Picks the reset kind from the raw sources with their gating applied.
// Assumes every source is already synchronised to mclk.
`timescale 1ns/100ps
`default_nettype none
module reset_kind_sel
	import power_reset_pkg::*;
(
	input wire logic pinRst,
	input wire logic dogExpire,
	input wire logic softReq,
	input wire logic lockup,
	input wire logic wake,
	input wire logic debugMode,
	input wire logic pinInDebug,
	input wire logic sysOff,
	output rst_kind_e kind
);

	// Strongest target set wins when sources coincide.
	always_comb
	begin
		kind = RS_NONE;
		if (pinRst && (!debugMode || pinInDebug))
			kind = RS_PIN;
		else if (dogExpire && !sysOff)
			kind = RS_DOG;
		else if (wake && sysOff)
			kind = RS_WAKE;
		else if (softReq && !sysOff)
			kind = RS_SOFT;
		else if (lockup && !debugMode && !sysOff)
			kind = RS_LOCK;
	end

endmodule // reset_kind_sel
`default_nettype wire
